// ---- dacmc_atten_step.sv ----
// Per-channel attenuation stepper toward the loaded target
`timescale 1ns/1ps
`default_nettype none
module dacmc_atten_step (
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    // Control
    input  wire logic       step_en_i,
    input  wire logic       force_mute_i,
    input  wire logic [7:0] target_i,
    // Result
    output logic      [7:0] level_o,
    output logic            muted_o
);
    import dacmc_pkg::*;

    logic [7:0] goal;

    assign goal = force_mute_i ? 8'h00 : target_i;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            level_o <= RST_ATTEN;
        end else if (step_en_i) begin
            if (level_o < goal) begin
                level_o <= level_o + 8'h01;
            end else if (level_o > goal) begin
                level_o <= level_o - 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            muted_o <= 1'b0;
        end else begin
            muted_o <= (level_o <= MUTE_CODE_MAX);
        end
    end
endmodule // dacmc_atten_step
`default_nettype wire

// ---- dacmc_host.sv ----
// Host controller model on the serial control port
`timescale 1ns/1ps
`default_nettype none
module dacmc_host (
    // Clock
    input  wire logic             core_clk_i,
    // Command and answer
    output logic                  cmd_valid_o,
    output dacmc_pkg::dacmc_cmd_t cmd_o,
    input  wire logic             rd_valid_i,
    input  wire logic       [7:0] rd_data_i
);
    import dacmc_pkg::*;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = 16'hA5C3;
    end
    task automatic xfer(input logic rd, input logic [6:0] idx, input logic [7:0] d,
                        output logic [7:0] got, output logic ok);
        @(negedge core_clk_i);
        cmd_o = {rd, idx, d};
        cmd_valid_o = 1'b1;
        @(negedge core_clk_i);
        cmd_valid_o = 1'b0;
        cmd_o = ~cmd_o;
        got = rd_data_i;
        ok = (rd_valid_i === rd);
    endtask
endmodule // dacmc_host
`default_nettype wire

// ---- dacmc_pkg.sv ----
// Package for the audio DAC mode-control register bank
package dacmc_pkg;
    localparam logic [6:0] IDX_LEFT_ATTEN  = 7'h10;
    localparam logic [6:0] IDX_RIGHT_ATTEN = 7'h11;
    localparam logic [6:0] IDX_FMT_EMPH    = 7'h12;
    localparam logic [6:0] IDX_PHASE_RATE  = 7'h13;
    localparam logic [6:0] IDX_SYS_MODE    = 7'h14;
    localparam logic [6:0] IDX_ZERO_CTRL   = 7'h15;
    localparam logic [6:0] IDX_ZERO_FLAGS  = 7'h16;
    localparam logic [6:0] IDX_DEV_NUMBER  = 7'h17;

    localparam int          CW_RW_BIT       = 15;
    localparam int          CW_IDX_HI       = 14;
    localparam int          CW_IDX_LO       = 8;

    localparam logic [7:0] RST_ATTEN       = 8'hFF;
    localparam logic [7:0] RST_FMT_EMPH    = 8'h50;
    localparam logic [7:0] RST_PHASE_RATE  = 8'h00;
    localparam logic [7:0] RST_SYS_MODE    = 8'h00;
    localparam logic [7:0] RST_ZERO_CTRL   = 8'h01;

    localparam logic [7:0] MASK_PHASE_RATE = 8'hF3;
    localparam logic [7:0] MASK_SYS_MODE   = 8'h7F;
    localparam logic [7:0] MASK_ZERO_CTRL  = 8'h07;

    localparam logic [7:0] MUTE_CODE_MAX   = 8'h0E;
    localparam logic [2:0] STEP_DIV_MAX    = 3'h7;

    // Arbitrary neutral device number default
    localparam logic [4:0] DEV_NUMBER_DEF  = 5'h00;

    typedef struct packed {
        logic       rd_not_wr;
        logic [6:0] index;
        logic [7:0] data;
    } dacmc_cmd_t;

    typedef struct packed {
        logic       atten_load_enable;
        logic [2:0] audio_format_sel;
        logic [1:0] deemph_rate_sel;
        logic       deemph_enable;
        logic       soft_mute;
        logic       phase_invert;
        logic [1:0] atten_step_rate;
        logic       output_disable;
        logic       rolloff_sel;
        logic       zero_auto_mute_en;
        logic       soft_system_reset;
        logic       bitstream_mode;
        logic       filter_bypass;
        logic       single_channel_mode;
        logic       single_channel_pick;
        logic [1:0] oversample_rate_sel;
        logic       sample_zero_out_en;
        logic [1:0] bitstream_zero_out_en;
    } dacmc_mode_t;
endpackage : dacmc_pkg

// ---- dacmc_regs.sv ----
// Mode-control register bank of a stereo audio DAC
// What this block does
// - Control word: bit 15 read select, bits 14..8 index, low byte data.
// - Indices 16 to 21: select one reads, select zero writes.
// - Indices 22 and 23 are read-only; writes ignored.
// - Left and right attenuation registers, 8 bits each, default 0 dB.
// - Three-bit audio format field, default 24-bit I2S.
// - De-emphasis rate field and enable bit, both default disabled.
// - Oversampling field in register 20: 64, 128 or 32 fs, default 64.
// - Single_channel_mode select bit and channel pick bit, defaults stereo and left.
// - System reset bit in register 20, default normal operation.
// - Bitstream mode bit in register 20, default disabled.
// - Filter bypass bit in register 20, default internal filter.
// - Infinite-zero auto mute enable in register 19, default off.
// - Sample-mode zero output enable in register 21, default on.
// - Two-bit bitstream zero output enable in register 21, default off.
// - Register 22 holds one zero flag per channel, one when zero.
// - Register 23 returns five-bit device number in bits 4..0.
// - Rolloff bit in register 19 selects sharp or slow, default sharp.
// - In bitstream mode the de-emphasis field selects analog FIR performance.
// - In bitstream mode the oversampling field selects analog FIR rate.
// - With load bit clear, attenuation targets hold; new data is stored but not loaded.
// - Codes 0 to 14 mute; others give half dB times code minus 255.
// - Attenuator steps every 1, 2, 4 or 8 word clocks.
`timescale 1ns/1ps
`default_nettype none
module dacmc_regs (
    // Clock and reset
    input  wire logic                core_clk_i,
    input  wire logic                rst_i,
    // Control word from serial port
    input  wire logic                cmd_valid_i,
    input  wire dacmc_pkg::dacmc_cmd_t cmd_i,
    output logic                     rd_valid_o,
    output logic               [7:0] rd_data_o,
    // Datapath status
    input  wire logic                word_clk_tick_i,
    input  wire logic                left_zero_i,
    input  wire logic                right_zero_i,
    input  wire logic          [4:0] device_number_i,
    // Mode outputs
    output dacmc_pkg::dacmc_mode_t   mode_o,
    output logic               [7:0] left_atten_level_o,
    output logic               [7:0] right_atten_level_o,
    output logic                     left_muted_o,
    output logic                     right_muted_o,
    output logic               [1:0] deemph_curve_o,
    output logic               [1:0] bitstream_fir_perf_o,
    output logic               [1:0] delta_sigma_rate_o,
    output logic               [1:0] bitstream_fir_rate_o
);
    import dacmc_pkg::*;

    logic [7:0] left_attenuation;
    logic [7:0] right_attenuation;
    logic [7:0] format_emphasis_mute;
    logic [7:0] phase_rate_filter;
    logic [7:0] system_mode;
    logic [7:0] zero_output_control;
    logic [7:0] left_target;
    logic [7:0] right_target;
    logic [1:0] zero_meta;
    logic [1:0] zero_sync;
    logic [4:0] dev_meta;
    logic [4:0] dev_sync;
    logic [4:0] dev_prev;
    logic [4:0] dev_number;
    logic [2:0] step_div;
    logic       step_en;
    logic [2:0] step_mask;
    logic       wr_en;
    logic       rd_en;
    logic       wr_left;
    logic       wr_right;
    logic       wr_fmt;
    logic       wr_phase;
    logic       wr_sys;
    logic       wr_zero;
    logic [7:0] next_rd_data;

    assign wr_en = cmd_valid_i && !cmd_i.rd_not_wr;
    assign rd_en = cmd_valid_i && cmd_i.rd_not_wr;

    always_comb begin
        wr_left  = 1'b0;
        wr_right = 1'b0;
        wr_fmt   = 1'b0;
        wr_phase = 1'b0;
        wr_sys   = 1'b0;
        wr_zero  = 1'b0;
        if (wr_en) begin
            unique case (cmd_i.index)
                IDX_LEFT_ATTEN:  wr_left  = 1'b1;
                IDX_RIGHT_ATTEN: wr_right = 1'b1;
                IDX_FMT_EMPH:    wr_fmt   = 1'b1;
                IDX_PHASE_RATE:  wr_phase = 1'b1;
                IDX_SYS_MODE:    wr_sys   = 1'b1;
                IDX_ZERO_CTRL:   wr_zero  = 1'b1;
                default:         ;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i || system_mode[6]) begin
            left_attenuation  <= RST_ATTEN;
            right_attenuation <= RST_ATTEN;
        end else begin
            if (wr_left) begin
                left_attenuation <= cmd_i.data;
            end
            if (wr_right) begin
                right_attenuation <= cmd_i.data;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i || system_mode[6]) begin
            left_target  <= RST_ATTEN;
            right_target <= RST_ATTEN;
        end else if (format_emphasis_mute[7]) begin
            left_target  <= left_attenuation;
            right_target <= right_attenuation;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i || system_mode[6]) begin
            format_emphasis_mute <= RST_FMT_EMPH;
        end else if (wr_fmt) begin
            format_emphasis_mute <= cmd_i.data;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i || system_mode[6]) begin
            phase_rate_filter <= RST_PHASE_RATE;
        end else if (wr_phase) begin
            phase_rate_filter <= cmd_i.data & MASK_PHASE_RATE;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i || system_mode[6]) begin
            system_mode <= RST_SYS_MODE;
        end else if (wr_sys) begin
            system_mode <= cmd_i.data & MASK_SYS_MODE;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i || system_mode[6]) begin
            zero_output_control <= RST_ZERO_CTRL;
        end else if (wr_zero) begin
            zero_output_control <= cmd_i.data & MASK_ZERO_CTRL;
        end
    end

    // Zero flag synchroniser
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            zero_meta <= 2'h0;
            zero_sync <= 2'h0;
        end else begin
            zero_meta <= {right_zero_i, left_zero_i};
            zero_sync <= zero_meta;
        end
    end

    // Device number synchroniser
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            dev_meta <= DEV_NUMBER_DEF;
            dev_sync <= DEV_NUMBER_DEF;
        end else begin
            dev_meta <= device_number_i;
            dev_sync <= dev_meta;
        end
    end

    // Device number taken once steady, no torn word
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            dev_prev   <= DEV_NUMBER_DEF;
            dev_number <= DEV_NUMBER_DEF;
        end else begin
            dev_prev <= dev_sync;
            if (dev_prev == dev_sync) begin
                dev_number <= dev_sync;
            end
        end
    end

    always_comb begin
        unique case (phase_rate_filter[6:5])
            2'h0: step_mask = 3'h0;
            2'h1: step_mask = 3'h1;
            2'h2: step_mask = 3'h3;
            2'h3: step_mask = STEP_DIV_MAX;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            step_div <= 3'h0;
        end else if (word_clk_tick_i) begin
            step_div <= step_div + 3'h1;
        end
    end

    assign step_en = word_clk_tick_i && ((step_div & step_mask) == 3'h0);

    dacmc_atten_step u_left (
        .core_clk_i   (core_clk_i),
        .rst_i        (rst_i),
        .step_en_i    (step_en),
        .force_mute_i (format_emphasis_mute[0]),
        .target_i     (left_target),
        .level_o      (left_atten_level_o),
        .muted_o      (left_muted_o)
    );

    dacmc_atten_step u_right (
        .core_clk_i   (core_clk_i),
        .rst_i        (rst_i),
        .step_en_i    (step_en),
        .force_mute_i (format_emphasis_mute[0]),
        .target_i     (right_target),
        .level_o      (right_atten_level_o),
        .muted_o      (right_muted_o)
    );

    always_comb begin
        unique case (cmd_i.index)
            IDX_LEFT_ATTEN:  next_rd_data = left_attenuation;
            IDX_RIGHT_ATTEN: next_rd_data = right_attenuation;
            IDX_FMT_EMPH:    next_rd_data = format_emphasis_mute;
            IDX_PHASE_RATE:  next_rd_data = phase_rate_filter;
            IDX_SYS_MODE:    next_rd_data = system_mode;
            IDX_ZERO_CTRL:   next_rd_data = zero_output_control;
            IDX_ZERO_FLAGS:  next_rd_data = {6'h00, zero_sync};
            IDX_DEV_NUMBER:  next_rd_data = {3'h0, dev_number};
            default:         next_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o  <= 8'h00;
        end else begin
            rd_valid_o <= rd_en;
            if (rd_en) begin
                rd_data_o <= next_rd_data;
            end
        end
    end

    always_comb begin
        mode_o.atten_load_enable     = format_emphasis_mute[7];
        mode_o.audio_format_sel      = format_emphasis_mute[6:4];
        mode_o.deemph_rate_sel       = format_emphasis_mute[3:2];
        mode_o.deemph_enable         = format_emphasis_mute[1];
        mode_o.soft_mute             = format_emphasis_mute[0];
        mode_o.phase_invert          = phase_rate_filter[7];
        mode_o.atten_step_rate       = phase_rate_filter[6:5];
        mode_o.output_disable        = phase_rate_filter[4];
        mode_o.rolloff_sel           = phase_rate_filter[1];
        mode_o.zero_auto_mute_en     = phase_rate_filter[0];
        mode_o.soft_system_reset     = system_mode[6];
        mode_o.bitstream_mode        = system_mode[5];
        mode_o.filter_bypass         = system_mode[4];
        mode_o.single_channel_mode   = system_mode[3];
        mode_o.single_channel_pick   = system_mode[2];
        mode_o.oversample_rate_sel   = system_mode[1:0];
        mode_o.sample_zero_out_en    = zero_output_control[0];
        mode_o.bitstream_zero_out_en = zero_output_control[2:1];
    end

    assign deemph_curve_o       = system_mode[5] ? 2'h0 : format_emphasis_mute[3:2];
    assign bitstream_fir_perf_o = system_mode[5] ? format_emphasis_mute[3:2] : 2'h0;
    assign delta_sigma_rate_o   = system_mode[5] ? 2'h0 : system_mode[1:0];
    assign bitstream_fir_rate_o = system_mode[5] ? system_mode[1:0] : 2'h0;
endmodule // dacmc_regs
`default_nettype wire

// ---- dacmc_regs_properties.sv ----
// Checker for the DAC mode-control register bank
`timescale 1ns/1ps
`default_nettype none
module dacmc_regs_properties (
    // Clock and reset
    input wire logic                   core_clk_i,
    input wire logic                   rst_i,
    // Command and answer
    input wire logic                   cmd_valid_i,
    input wire dacmc_pkg::dacmc_cmd_t  cmd_i,
    input wire logic                   rd_valid_o,
    input wire logic             [7:0] rd_data_o,
    input wire logic                   word_clk_tick_i,
    // Mode outputs
    input wire dacmc_pkg::dacmc_mode_t mode_o,
    input wire logic             [7:0] left_atten_level_o,
    input wire logic                   left_muted_o,
    input wire logic             [1:0] deemph_curve_o,
    input wire logic             [1:0] bitstream_fir_perf_o,
    input wire logic             [1:0] delta_sigma_rate_o,
    input wire logic             [1:0] bitstream_fir_rate_o
);
    import dacmc_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    wire logic rd_c = cmd_valid_i && cmd_i.rd_not_wr;
    wire logic wr_c = cmd_valid_i && !cmd_i.rd_not_wr;
    a_read_answer: assert property (rd_c |=> rd_valid_o)
        else $error("read not answered");
    a_fmt_write: assert property (wr_c && cmd_i.index == IDX_FMT_EMPH |=>
        mode_o.audio_format_sel == $past(cmd_i.data[6:4])) else $error("format not written");
    a_ro_ignore: assert property (wr_c && cmd_i.index > IDX_ZERO_CTRL |=> $stable(mode_o))
        else $error("read-only write changed mode");
    a_fir_rate: assert property (mode_o.bitstream_mode |-> delta_sigma_rate_o == 2'h0 &&
        bitstream_fir_rate_o == mode_o.oversample_rate_sel) else $error("rate routing");
    a_fir_perf: assert property (!mode_o.bitstream_mode |-> bitstream_fir_perf_o == 2'h0 &&
        deemph_curve_o == mode_o.deemph_rate_sel) else $error("de-emphasis routing");
    a_mute_flag: assert property (1'b1 |=>
        left_muted_o == ($past(left_atten_level_o) <= 8'h0E)) else $error("mute flag wrong");
    a_level_hold: assert property (!word_clk_tick_i |=> $stable(left_atten_level_o))
        else $error("level moved without tick");
    a_softrst_restore: assert property (wr_c && cmd_i.index == IDX_SYS_MODE &&
        cmd_i.data[6] |-> ##2 !mode_o.soft_system_reset && mode_o.audio_format_sel == 3'h5)
        else $error("soft reset not restored");
    a_reserved_zero: assert property (rd_c && cmd_i.index == IDX_ZERO_CTRL |=>
        rd_data_o[7:3] == 5'h00) else $error("reserved bits not zero");
    c_read: cover property (rd_c);
    c_bitstream: cover property (mode_o.bitstream_mode);
    c_muted: cover property (left_muted_o);
endmodule // dacmc_regs_properties
bind dacmc_regs dacmc_regs_properties u_dacmc_regs_properties (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .word_clk_tick_i(word_clk_tick_i),
    .mode_o(mode_o), .left_atten_level_o(left_atten_level_o), .left_muted_o(left_muted_o),
    .deemph_curve_o(deemph_curve_o), .bitstream_fir_perf_o(bitstream_fir_perf_o),
    .delta_sigma_rate_o(delta_sigma_rate_o), .bitstream_fir_rate_o(bitstream_fir_rate_o)
);
`default_nettype wire

// ---- tb.sv ----
// Self-checking testbench for the DAC mode-control register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dacmc_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cmd_valid, rd_valid, left_mut, right_mut, ok;
    logic  [1:0] dc, dsr, fp, fr;
    logic        tick = 1'b0, lz = 1'b0, rz = 1'b0;
    logic  [7:0] rd_data, left_lvl, right_lvl, got;
    logic  [4:0] dev_num = 5'h00;
    dacmc_cmd_t  cmd;
    dacmc_mode_t mode;
    int          errors = 0, cmp_count = 0, cyc = 0;
    int          ref_r [16:23];
    dacmc_regs u_dacmc_regs (.core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid),
        .cmd_i(cmd), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .word_clk_tick_i(tick),
        .left_zero_i(lz), .right_zero_i(rz), .device_number_i(dev_num), .mode_o(mode),
        .left_atten_level_o(left_lvl), .right_atten_level_o(right_lvl),
        .left_muted_o(left_mut), .right_muted_o(right_mut), .deemph_curve_o(dc),
        .bitstream_fir_perf_o(fp), .delta_sigma_rate_o(dsr), .bitstream_fir_rate_o(fr));
    dacmc_host u_dacmc_host (.core_clk_i(core_clk_i), .cmd_valid_o(cmd_valid), .cmd_o(cmd),
        .rd_valid_i(rd_valid), .rd_data_i(rd_data));
    always #5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            give_verdict();
        end
    end
    task give_verdict();
        if (errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [23:0] g, input logic [23:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task reset_model();
        ref_r[16] = 8'hFF; ref_r[17] = 8'hFF; ref_r[18] = 8'h50;
        ref_r[19] = 8'h00; ref_r[20] = 8'h00; ref_r[21] = 8'h01;
    endtask
    function logic [23:0] em();
        return {ref_r[18][7:0], ref_r[19][7:4], ref_r[19][1:0], ref_r[20][6:0],
                ref_r[21][0], ref_r[21][2:1]};
    endfunction
    function logic [7:0] expv(input int i);
        if (i >= 16 && i <= 21) return ref_r[i][7:0];
        if (i == 22) return {6'h00, rz, lz};
        if (i == 23) return {3'h0, dev_num};
        return 8'h00;
    endfunction
    function logic [7:0] er();
        if (ref_r[20][5]) return {4'h0, ref_r[18][3:2], ref_r[20][1:0]};
        return {ref_r[18][3:2], ref_r[20][1:0], 4'h0};
    endfunction
    task wr(input int i, input logic [7:0] d);
        u_dacmc_host.xfer(1'b0, i[6:0], d, got, ok);
        chk(ok, 1'b1);
        case (i)
            16, 17, 18: ref_r[i] = d;
            19: ref_r[i] = d & 8'hF3;
            20: ref_r[i] = d & 8'h7F;
            21: ref_r[i] = d & 8'h07;
            default: ;
        endcase
        if (i == 20 && d[6]) reset_model();
    endtask
    task rd(input int i);
        u_dacmc_host.xfer(1'b1, i[6:0], 8'h00, got, ok);
        chk(ok, 1'b1);
        chk(got, expv(i));
    endtask
    task tk(input int n);
        repeat (n) begin
            @(negedge core_clk_i) tick = 1'b1;
            @(negedge core_clk_i) tick = 1'b0;
        end
    endtask
    initial begin
        int j, i;
        logic [7:0] d;
        j = $urandom(92);
        reset_model();
        repeat (4) @(posedge core_clk_i);
        @(negedge core_clk_i) rst_i = 1'b0;
        for (j = 14; j < 25; j++) rd(j);
        chk(mode, em());
        wr(16, 8'h05);
        tk(20);
        chk(left_lvl, 8'hFF);
        wr(18, 8'hD0);
        tk(260);
        chk({left_lvl, right_lvl, 6'h00, right_mut, left_mut}, 24'h05FF01);
        wr(19, 8'h60);
        wr(16, 8'h0F);
        tk(16);
        chk(left_lvl, 8'h07);
        wr(18, 8'hD1);
        tk(16);
        chk({left_lvl, 7'h00, left_mut}, 16'h0501);
        lz = 1'b1;
        dev_num = 5'($urandom);
        repeat (3) @(negedge core_clk_i);
        rd(22);
        rd(23);
        for (j = 0; j < 60; j++) begin
            i = 16 + $urandom_range(7);
            d = 8'($urandom);
            if (i == 20) d[6] = 1'b0;
            wr(i, d);
            rd(16 + $urandom_range(7));
            chk(mode, em());
            chk({dc, dsr, fp, fr}, er());
        end
        wr(20, 8'h40);
        repeat (2) @(negedge core_clk_i);
        for (j = 16; j < 22; j++) rd(j);
        chk(mode, em());
        chk({dc, dsr, fp, fr}, er());
        give_verdict();
    end
endmodule // tb
`default_nettype wire
